/* logic/rea_accumulator.sv */
/*
 Reactive energy accumulator with AXI4-Lite register slave, modes, divider,
 gain, no-load suppression, line-cycle accumulation, waveform samples and an
 active-low energy pulse. Assumes a signed reactive power sample, an active
 power sign and a zero-crossing pulse all on clk.
*/
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module rea_accumulator
    import rea_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power datapath
    input wire logic signed [rea_pkg::SAMP_W-1:0] reactive_power,
    input wire logic active_negative,
    input wire logic active_noload,
    input wire logic zero_cross,
    // Outputs
    output logic energy_pulse_out_n,
    output logic cycle_irq,
    output logic energy_irq
);
    import rea_pkg::*;

    logic [7:0] waveform_select_cfg, accumulation_mode_cfg, irq_enable_high;
    logic [7:0] irq_status_high, reactive_energy_divider, energy_irq_en, energy_status;
    logic [1:0] reactive_noload_level;
    logic [11:0] reactive_gain;
    logic [15:0] half_cycle_count, half_cnt;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] line_acc;
    logic [TOT_W-1:0] line_reactive_energy;
    logic [2:0] tick_cnt;
    logic tick;
    logic line_armed;

    // Accumulation tick
    always_ff @(posedge clk)
    begin
        if (rst || tick_cnt == ACC_DIV - 3'h1)
            tick_cnt <= 3'h0;
        else
            tick_cnt <= tick_cnt + 3'h1;
    end
    assign tick = (tick_cnt == ACC_DIV - 3'h1);

    // Gain, mode, no-load and divider path
    logic signed [SAMP_W+12:0] gained_full;
    logic signed [SAMP_W-1:0] gained, moded, mag, divided;
    logic [SAMP_W-1:0] th;
    logic sign_f, abs_m, suppress;
    assign gained_full = (37'(reactive_power) <<< 12) + 37'(reactive_power) * 37'(signed'(reactive_gain));
    assign gained = SAMP_W'(gained_full >>> 12);
    assign abs_m = accumulation_mode_cfg[ACC_ABSOLUTE];
    assign sign_f = accumulation_mode_cfg[ACC_SIGN_FOLLOW] && !abs_m;
    assign mag = gained[SAMP_W-1] ? -gained : gained;
    always_comb
    begin
        if (abs_m)
            moded = mag;
        else if (sign_f && active_negative)
            moded = -gained;
        else
            moded = gained;
        unique case (reactive_noload_level)
            2'b00: th = '0;
            2'b01: th = NL_TH1;
            2'b10: th = NL_TH2;
            2'b11: th = NL_TH3;
        endcase
    end
    // Threshold no-load runs in every mode, the active_noload flag only in absolute mode
    assign suppress = (reactive_noload_level != 2'b00 && mag < th)
        || (abs_m && active_noload);
    // Divider value 0 behaves like 1
    assign divided = (reactive_energy_divider == 8'h00) ? moded
        : moded / signed'({16'h0000, reactive_energy_divider});

    logic [ACC_W-1:0] add_val, next_acc;
    assign add_val = suppress ? '0 : ACC_W'(divided);
    assign next_acc = acc + add_val;

    // Bus read-clear request
    logic rd_clear;
    logic [TOT_W-1:0] tot;
    assign tot = acc[ACC_W-1 -: TOT_W];

    always_ff @(posedge clk)
    begin
        if (rst)
            acc <= '0;
        else if (rd_clear)
            acc <= {{TOT_W{1'b0}}, tick ? next_acc[ACC_W-TOT_W-1:0]
                : acc[ACC_W-TOT_W-1:0]};
        else if (tick)
            acc <= next_acc;
    end

    // Energy events: wrap and half-full on the total
    logic [TOT_W-1:0] ntot;
    logic ev_half, ev_over, ev_under, est_clr_we;
    logic [7:0] est_clr;
    assign ntot = next_acc[ACC_W-1 -: TOT_W];
    assign ev_over = tick && !rd_clear && !tot[23] && ntot[23] && !add_val[ACC_W-1];
    assign ev_under = tick && !rd_clear && tot[23] && !ntot[23] && add_val[ACC_W-1];
    assign ev_half = tick && !rd_clear && (tot[23] == ntot[23]) && (tot[22] != ntot[22]);
    always_ff @(posedge clk)
    begin
        if (rst)
            energy_status <= 8'h00;
        else
            energy_status <= (energy_status & ~(est_clr_we ? est_clr : 8'h00))
                | {5'h00, ev_under, ev_over, ev_half};
    end
    assign energy_irq = |(energy_status & energy_irq_en);

    // Line-cycle accumulation
    logic hc_we, cyc_done;
    assign cyc_done = line_armed && zero_cross && (half_cnt + 16'h1 >= half_cycle_count);
    always_ff @(posedge clk)
    begin
        if (rst || hc_we)
        begin
            line_armed <= 1'b0;
            half_cnt <= 16'h0;
            line_acc <= '0;
            line_reactive_energy <= '0;
        end
        else
        begin
            if (zero_cross)
                line_armed <= 1'b1;
            if (cyc_done)
            begin
                half_cnt <= 16'h0;
                line_reactive_energy <= line_acc[ACC_W-1 -: TOT_W];
                line_acc <= tick ? add_val : '0;
            end
            else
            begin
                if (line_armed && zero_cross)
                    half_cnt <= half_cnt + 16'h1;
                if (line_armed && tick)
                    line_acc <= line_acc + add_val;
            end
        end
    end

    // Cycle-done flag: set wins over clear
    logic wave_stb;
    logic ist_clr_we;
    logic [7:0] ist_clr;
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_status_high <= 8'h00;
        else
        begin
            irq_status_high <= irq_status_high & ~(ist_clr_we ? ist_clr : 8'h00);
            if (cyc_done)
                irq_status_high[IRQH_CYCLE] <= 1'b1;
            if (wave_stb && irq_enable_high[IRQH_WAVE])
                irq_status_high[IRQH_WAVE] <= 1'b1;
        end
    end
    assign cycle_irq = |(irq_status_high & irq_enable_high);

    // Waveform sampling
    logic [31:0] wave_cnt;
    logic [31:0] wave_lim;
    logic [SAMP_W-1:0] wave_data;
    assign wave_lim = 32'(WAVE_BASE_CYC) << waveform_select_cfg[WSEL_RATE_LO +: 2];
    assign wave_stb = (wave_cnt >= wave_lim - 32'h1);
    always_ff @(posedge clk)
    begin
        if (rst || wave_stb)
            wave_cnt <= 32'h0;
        else
            wave_cnt <= wave_cnt + 32'h1;
    end
    always_ff @(posedge clk)
    begin
        if (rst)
            wave_data <= '0;
        else if (wave_stb && waveform_select_cfg[WSEL_REACTIVE] && irq_enable_high[IRQH_WAVE])
            wave_data <= gained;
    end

    // Pulse output from the magnitude of gained power
    logic [47:0] pulse_acc;
    logic [7:0] pulse_cnt;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pulse_acc <= '0;
            pulse_cnt <= 8'h00;
        end
        else
        begin
            if (pulse_cnt != 8'h00)
                pulse_cnt <= pulse_cnt - 8'h01;
            if (tick && !suppress)
            begin
                if (48'(mag) + pulse_acc >= PULSE_STEP)
                begin
                    pulse_acc <= 48'(mag) + pulse_acc - PULSE_STEP;
                    pulse_cnt <= PULSE_LEN;
                end
                else
                    pulse_acc <= 48'(mag) + pulse_acc;
            end
        end
    end
    assign energy_pulse_out_n = (pulse_cnt == 8'h00);

    // AXI4-Lite write
    logic aw_hold, w_hold;
    logic [7:0] aw_idx;
    logic [31:0] wd;
    logic do_wr;
    logic wr_ok;
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready = !w_hold && !s_axi_bvalid;
    assign do_wr = aw_hold && w_hold && !s_axi_bvalid;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_idx <= 8'h00;
            wd <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_idx <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                wd <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            end
            if (do_wr)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    always_comb
    begin
        unique case (aw_idx)
            IDX_WAVE_SEL, IDX_ACC_MODE, IDX_IRQ_EN_HI, IDX_IRQ_ST_HI, IDX_DIVIDER,
            IDX_HALF_CYC, IDX_GAIN, IDX_NOLOAD, IDX_ENERGY_ST, IDX_ENERGY_EN: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end
    assign hc_we = do_wr && aw_idx == IDX_HALF_CYC;
    assign ist_clr_we = do_wr && aw_idx == IDX_IRQ_ST_HI;
    assign ist_clr = wd[7:0];
    assign est_clr_we = do_wr && aw_idx == IDX_ENERGY_ST;
    assign est_clr = wd[7:0];
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            waveform_select_cfg <= 8'h00;
            accumulation_mode_cfg <= ACC_MODE_RST;
            irq_enable_high <= 8'h00;
            reactive_energy_divider <= DIV_RST;
            half_cycle_count <= HALF_CYC_RST;
            reactive_gain <= 12'h000;
            reactive_noload_level <= 2'b00;
            energy_irq_en <= 8'h00;
        end
        else if (do_wr)
        begin
            unique case (aw_idx)
                IDX_WAVE_SEL: waveform_select_cfg <= wd[7:0];
                IDX_ACC_MODE: accumulation_mode_cfg <= wd[7:0];
                IDX_IRQ_EN_HI: irq_enable_high <= wd[7:0];
                IDX_DIVIDER: reactive_energy_divider <= wd[7:0];
                IDX_HALF_CYC: half_cycle_count <= wd[15:0];
                IDX_GAIN: reactive_gain <= wd[11:0];
                IDX_NOLOAD: reactive_noload_level <= wd[1:0];
                IDX_ENERGY_EN: energy_irq_en <= wd[7:0];
                default: ;
            endcase
        end
    end

    // AXI4-Lite read
    logic [31:0] rmux;
    logic rok;
    always_comb
    begin
        rmux = 32'h0;
        rok = 1'b1;
        unique case (s_axi_araddr[9:2])
            IDX_WAVE_SEL: rmux = {24'h0, waveform_select_cfg};
            IDX_ACC_MODE: rmux = {24'h0, accumulation_mode_cfg};
            IDX_IRQ_EN_HI: rmux = {24'h0, irq_enable_high};
            IDX_IRQ_ST_HI: rmux = {24'h0, irq_status_high};
            IDX_TOTAL, IDX_READ_CLR: rmux = {8'h0, tot};
            IDX_DIVIDER: rmux = {24'h0, reactive_energy_divider};
            IDX_HALF_CYC: rmux = {16'h0, half_cycle_count};
            IDX_LINE_NRG: rmux = {8'h0, line_reactive_energy};
            IDX_GAIN: rmux = {20'h0, reactive_gain};
            IDX_NOLOAD: rmux = {30'h0, reactive_noload_level};
            IDX_ENERGY_ST: rmux = {24'h0, energy_status};
            IDX_ENERGY_EN: rmux = {24'h0, energy_irq_en};
            IDX_WAVE_DATA: rmux = {8'h0, wave_data};
            default: rok = 1'b0;
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_clear = s_axi_arvalid && s_axi_arready
        && s_axi_araddr[9:2] == IDX_READ_CLR;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rmux;
            s_axi_rresp <= rok ? 2'b00 : 2'b10;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks
    chk_tick_period: assert property (@(posedge clk) disable iff (rst)
        tick |=> !tick [*4] ##1 tick) else $error("tick spacing wrong");
    chk_rc_clears: assert property (@(posedge clk) disable iff (rst)
        rd_clear |=> acc[ACC_W-1 -: TOT_W] == '0) else $error("read-clear missed");
    chk_rc_returns: assert property (@(posedge clk) disable iff (rst)
        rd_clear |=> s_axi_rdata[23:0] == $past(tot)) else $error("read-clear data");
    chk_cycle_flag: assert property (@(posedge clk) disable iff (rst)
        cyc_done |=> irq_status_high[IRQH_CYCLE]) else $error("cycle flag lost");
    chk_cycle_irq: assert property (@(posedge clk) disable iff (rst)
        irq_status_high[IRQH_CYCLE] && irq_enable_high[IRQH_CYCLE] |-> cycle_irq)
        else $error("cycle irq not raised");
    chk_new_count: assert property (@(posedge clk) disable iff (rst)
        hc_we |=> line_reactive_energy == '0 && !line_armed)
        else $error("line energy not cleared");
    chk_suppress: assert property (@(posedge clk) disable iff (rst)
        tick && suppress && !rd_clear |=> acc == $past(acc)) else $error("no-load leak");
    chk_abs_mode: assert property (@(posedge clk) disable iff (rst)
        abs_m && !suppress |-> !add_val[ACC_W-1] || divided == '0)
        else $error("absolute mode negative");
    chk_div_one: assert property (@(posedge clk) disable iff (rst)
        reactive_energy_divider == 8'h00 |-> divided == moded) else $error("div zero");
    chk_pulse_len: assert property (@(posedge clk) disable iff (rst)
        $fell(energy_pulse_out_n) |-> !energy_pulse_out_n [*8]) else $error("pulse short");
endmodule : rea_accumulator

/* logic/rea_pkg.sv */
/*
 Constants for the reactive energy accumulator: register indices, field
 positions, reset values and timing. Assumes a 32-bit AXI4-Lite bus with
 registers at four times their index.
*/
package rea_pkg;
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_WAVE_SEL = 8'h0d;
    localparam logic [7:0] IDX_ACC_MODE = 8'h0f;
    localparam logic [7:0] IDX_IRQ_EN_HI = 8'hdb;
    localparam logic [7:0] IDX_IRQ_ST_HI = 8'hde;
    localparam logic [7:0] IDX_TOTAL = 8'h40;
    localparam logic [7:0] IDX_DIVIDER = 8'h41;
    localparam logic [7:0] IDX_READ_CLR = 8'h42;
    localparam logic [7:0] IDX_HALF_CYC = 8'h43;
    localparam logic [7:0] IDX_LINE_NRG = 8'h44;
    localparam logic [7:0] IDX_GAIN = 8'h45;
    localparam logic [7:0] IDX_NOLOAD = 8'h46;
    localparam logic [7:0] IDX_ENERGY_ST = 8'h47;
    localparam logic [7:0] IDX_ENERGY_EN = 8'h48;
    localparam logic [7:0] IDX_WAVE_DATA = 8'h49;
    // Field positions
    localparam int ACC_SIGN_FOLLOW = 0;
    localparam int ACC_ABSOLUTE = 1;
    localparam int IRQH_WAVE = 0;
    localparam int IRQH_CYCLE = 1;
    localparam int EST_HALF = 0;
    localparam int EST_OVER = 1;
    localparam int EST_UNDER = 2;
    localparam int WSEL_REACTIVE = 3;
    localparam int WSEL_RATE_LO = 4;
    // Widths
    localparam int ACC_W = 49;
    localparam int TOT_W = 24;
    localparam int SAMP_W = 24;
    localparam int LINE_W = 16;
    // Reset values
    localparam logic [7:0] ACC_MODE_RST = 8'h00;
    localparam logic [15:0] HALF_CYC_RST = 16'hffff;
    localparam logic [7:0] DIV_RST = 8'h00;
    // Timing: one accumulation every 5 master clocks
    localparam logic [2:0] ACC_DIV = 3'h5;
    localparam real CLK_MHZ = 200.0;
    localparam real WAVE_KSPS_FAST = 27.9;
    localparam int WAVE_BASE_CYC = int'(CLK_MHZ * 1000.0 / WAVE_KSPS_FAST);
    // No-load thresholds in sample LSBs, one per non-zero code
    localparam logic [23:0] NL_TH1 = 24'h000100;
    localparam logic [23:0] NL_TH2 = 24'h000080;
    localparam logic [23:0] NL_TH3 = 24'h000040;
    // Pulse output: energy step per pulse and pulse width
    localparam logic [47:0] PULSE_STEP = 48'h0000_0100_0000;
    localparam logic [7:0] PULSE_LEN = 8'h10;
endpackage : rea_pkg

/* test/rea_power_src.sv */
/*
 Model of the power datapath that feeds the accumulator: a held reactive
 sample, active power direction and no-load flags, and zero-crossing pulses.
 Assumes its tasks are called from a bench process that is synchronous to clk.
*/
`timescale 1ns/1ps
module rea_power_src
    import rea_pkg::*;
(
    // Clock
    input wire logic clk,
    // Power datapath
    output logic signed [rea_pkg::SAMP_W-1:0] reactive_power,
    output logic active_negative,
    output logic active_noload,
    output logic zero_cross
);
    initial
    begin
        reactive_power = '0;
        active_negative = 1'b0;
        active_noload = 1'b0;
        zero_cross = 1'b0;
    end

    // Holding for a whole number of tick periods lands exactly k samples,
    // whatever the phase of the internal divider
    task automatic burst(input logic signed [rea_pkg::SAMP_W-1:0] s, input int k);
        @(posedge clk);
        reactive_power <= s;
        repeat (int'(ACC_DIV) * k) @(posedge clk);
        reactive_power <= '0;
    endtask : burst

    task automatic set_flags(input logic neg, input logic nl);
        @(posedge clk);
        active_negative <= neg;
        active_noload <= nl;
    endtask : set_flags

    task automatic crossing();
        @(posedge clk);
        zero_cross <= 1'b1;
        @(posedge clk);
        zero_cross <= 1'b0;
    endtask : crossing
endmodule : rea_power_src

/* test/tb_top.sv */
/*
 Self-checking bench for the reactive energy accumulator: register access
 over AXI4-Lite, accumulation modes, divider, read-clear, line-cycle and
 waveform events. Assumes the power source model drives the datapath.
*/
`timescale 1ns/1ps
module tb_top;
    import rea_pkg::*;

    logic clk;
    logic rst;
    logic [11:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic signed [SAMP_W-1:0] reactive_power;
    logic active_negative;
    logic active_noload;
    logic zero_cross;
    logic energy_pulse_out_n;
    logic cycle_irq;
    logic energy_irq;
    logic pulse_seen;
    int errors;
    int n_compared;
    int cycles;

    rea_accumulator rea_accumulator_i (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .reactive_power(reactive_power), .active_negative(active_negative),
        .active_noload(active_noload), .zero_cross(zero_cross),
        .energy_pulse_out_n(energy_pulse_out_n), .cycle_irq(cycle_irq),
        .energy_irq(energy_irq)
    );

    rea_power_src rea_power_src_i (
        .clk(clk), .reactive_power(reactive_power), .active_negative(active_negative),
        .active_noload(active_noload), .zero_cross(zero_cross)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic close_out();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (!rst && energy_pulse_out_n === 1'b0)
            pulse_seen <= 1'b1;
        if (cycles == 40000)
        begin
            errors = errors + 1;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Ready is sampled at the edge before our own updates land
    task automatic axw(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axr

    // Sixteen samples of 2^22 make two units of the 24-bit total
    task automatic run(input logic [7:0] mode, input logic neg, input logic nl,
        input logic signed [23:0] s, input logic [7:0] dv, input logic [23:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axw(IDX_ACC_MODE, {24'h000000, mode}, r);
        axw(IDX_DIVIDER, {24'h000000, dv}, r);
        rea_power_src_i.set_flags(neg, nl);
        rea_power_src_i.burst(s, 16);
        axr(IDX_TOTAL, d, r);
        chk({8'h00, d[23:0]}, {8'h00, exp});
        axr(IDX_READ_CLR, d, r);
        chk({8'h00, d[23:0]}, {8'h00, exp});
    endtask : run

    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        rst = 1'b1;
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready, pulse_seen} = '0;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        chk({31'h0, energy_pulse_out_n}, 32'h1);
        axr(IDX_ACC_MODE, d, r);
        chk(d, 32'h0);
        axr(IDX_HALF_CYC, d, r);
        chk(d, 32'h0000ffff);
        axw(8'h00, 32'h1, r);
        chk({30'h0, r}, 32'h2);
        axr(8'h00, d, r);
        chk({30'h0, r}, 32'h2);
        axw(IDX_TOTAL, 32'h5, r);
        chk({30'h0, r}, 32'h2);
        run(8'h00, 1'b0, 1'b0, 24'sh400000, 8'h00, 24'h000002);
        run(8'h00, 1'b0, 1'b0, -24'sh400000, 8'h00, 24'hfffffe);
        run(8'h01, 1'b1, 1'b0, 24'sh400000, 8'h00, 24'hfffffe);
        run(8'h01, 1'b0, 1'b0, 24'sh400000, 8'h00, 24'h000002);
        run(8'h02, 1'b0, 1'b0, -24'sh400000, 8'h00, 24'h000002);
        run(8'h03, 1'b0, 1'b0, -24'sh400000, 8'h00, 24'h000002);
        run(8'h02, 1'b0, 1'b1, 24'sh400000, 8'h00, 24'h000000);
        run(8'h00, 1'b0, 1'b0, 24'sh400000, 8'h02, 24'h000001);
        run(8'h00, 1'b0, 1'b0, 24'sh400000, 8'h01, 24'h000002);
        axr(IDX_TOTAL, d, r);
        chk({8'h00, d[23:0]}, 32'h0);
        chk({31'h0, pulse_seen}, 32'h1);
        // Totals stayed tiny, so no energy event may have been raised
        axr(IDX_ENERGY_ST, d, r);
        chk(d, 32'h0);
        chk({31'h0, energy_irq}, 32'h0);
        // Line cycle of two half cycles, energy only inside the first one
        axw(IDX_IRQ_EN_HI, 32'h2, r);
        axw(IDX_HALF_CYC, 32'h2, r);
        rea_power_src_i.crossing();
        rea_power_src_i.burst(24'sh400000, 16);
        rea_power_src_i.crossing();
        rea_power_src_i.crossing();
        repeat (4) @(posedge clk);
        chk({31'h0, cycle_irq}, 32'h1);
        axr(IDX_LINE_NRG, d, r);
        chk({8'h00, d[23:0]}, 32'h2);
        axw(IDX_IRQ_ST_HI, 32'h2, r);
        @(posedge clk);
        chk({31'h0, cycle_irq}, 32'h0);
        rea_power_src_i.crossing();
        rea_power_src_i.crossing();
        repeat (4) @(posedge clk);
        chk({31'h0, cycle_irq}, 32'h1);
        axr(IDX_LINE_NRG, d, r);
        chk({8'h00, d[23:0]}, 32'h0);
        // Waveform samples of reactive power at the fastest rate
        axw(IDX_WAVE_SEL, 32'h8, r);
        axw(IDX_IRQ_EN_HI, 32'h3, r);
        repeat (WAVE_BASE_CYC + 50) @(posedge clk);
        axr(IDX_IRQ_ST_HI, d, r);
        chk({31'h0, d[IRQH_WAVE]}, 32'h1);
        close_out();
    end
endmodule : tb_top
